/* ecp_cfg.svh */
/*
 * Offsets, field positions, reset values and timing counts of the external control port.
 * Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
`ifndef ECP_CFG_SVH
`define ECP_CFG_SVH

// register byte offsets
`define ECP_OFF_CTRL      8'h00
`define ECP_OFF_STATUS    8'h04
`define ECP_OFF_IRQ_STAT  8'h08
`define ECP_OFF_IRQ_MASK  8'h0C
`define ECP_OFF_RESULT    8'h10
`define ECP_OFF_CONV      8'h14
`define ECP_OFF_RESET     8'h18
`define ECP_OFF_IF_CFG    8'h1C
`define ECP_OFF_SAVE      8'h20

// control fields
`define ECP_CTRL_EXT      0
`define ECP_CTRL_FALL     1
`define ECP_CTRL_BCD      2
`define ECP_CTRL_GP_LO    4
`define ECP_CTRL_DEF      32'h0000_0000
`define ECP_IF_CFG_DEF    32'h0000_0000

// result fields
`define ECP_RES_RANGE_LO  20
`define ECP_RES_ABOVE     24
`define ECP_RES_PASS      25
`define ECP_RES_UNDER     26
`define ECP_RES_FAULT     27

// reset command bits
`define ECP_RST_MEAS      0
`define ECP_RST_SYS       1
`define ECP_RST_REMOTE    2

// event bits of the sticky status
`define ECP_EV_MEASURE_START       0
`define ECP_EV_ZADJ       1
`define ECP_EV_PRINT      2
`define ECP_EV_LOAD       3
`define ECP_EV_END        4

// timing
`define ECP_CLK_HZ        25000000
`define ECP_QUIET_MS      10

`endif

/* ecp_pkg.sv */
/*
 * Types shared by the external control port modules.
 * Assumes the constants of ecp_cfg.svh.
 */
package ecp_pkg;
   typedef enum logic [1:0] {ECP_IDLE, ECP_BUSY, ECP_CLEAR} ecp_state_t;
   typedef logic [1:0] ecp_resp_t;
   localparam ecp_resp_t ECP_OKAY   = 2'h0;
   localparam ecp_resp_t ECP_DECERR = 2'h3;
endpackage : ecp_pkg

/* ecp_sync.sv */
/*
 * Two-flop synchroniser bank for the isolated control inputs.
 * Assumes inputs are asynchronous to clk; outputs lag by two edges.
 */
`timescale 1ns/1ps
`default_nettype none
module ecp_sync
   import ecp_pkg::*;
#(
   parameter int W = 4
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // pins and synchronised copies
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   if (W < 1) $error("ecp_sync: W must be at least 1");

   logic [W-1:0] stage1;

   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
         if (rst) begin
            stage1[i] <= 1'b0;
            dout[i]   <= 1'b0;
         end else begin
            stage1[i] <= din[i];
            dout[i]   <= stage1[i];
         end
      end
   end
endmodule : ecp_sync
`default_nettype wire

/* ecp_axil.sv */
/*
 * AXI4-Lite slave front end: turns bus transfers into one-cycle register strobes.
 * Assumes the register file decodes rd_addr combinationally and reports a hit.
 */
`timescale 1ns/1ps
`default_nettype none
module ecp_axil
   import ecp_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // write channels
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output ecp_resp_t        s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   // read channels
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output ecp_resp_t        s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // register file side
   output logic             wr_en,
   output logic [7:0]       wr_addr,
   output logic [31:0]      wr_data,
   output logic [3:0]       wr_strb,
   input  wire logic        wr_hit,
   output logic [7:0]       rd_addr,
   input  wire logic [31:0] rd_data,
   input  wire logic        rd_hit
);
   // both halves taken together, so the response cannot outrun either
   wire wr_take = s_awvalid && s_wvalid && !s_bvalid;
   wire rd_take = s_arvalid && !s_rvalid;

   assign s_awready = wr_take;
   assign s_wready  = wr_take;
   assign s_arready = rd_take;
   assign wr_en     = wr_take;
   assign wr_addr   = s_awaddr;
   assign wr_data   = s_wdata;
   assign wr_strb   = s_wstrb;
   assign rd_addr   = s_araddr;

   always_ff @(posedge clk) begin
      if (rst) begin
         s_bvalid <= 1'b0;
         s_bresp  <= ECP_OKAY;
      end else if (wr_take) begin
         s_bvalid <= 1'b1;
         s_bresp  <= wr_hit ? ECP_OKAY : ECP_DECERR;
      end else if (s_bready) begin
         s_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_rvalid <= 1'b0;
         s_rdata  <= 32'h0000_0000;
         s_rresp  <= ECP_OKAY;
      end else if (rd_take) begin
         s_rvalid <= 1'b1;
         s_rdata  <= rd_hit ? rd_data : 32'h0000_0000;
         s_rresp  <= rd_hit ? ECP_OKAY : ECP_DECERR;
      end else if (s_rready) begin
         s_rvalid <= 1'b0;
      end
   end
endmodule : ecp_axil
`default_nettype wire

/* ecp_port.sv */
/*
 * External control port of a resistance meter: trigger, zero-adjust, print and
 * preset-select inputs; end, conversion, judgment and digit outputs; presets and resets.
 * Assumes firmware performs the measurement and writes its result over AXI4-Lite.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ecp_cfg.svh"

// Notes on behaviour
// - System reset restores settings and clears every stored preset to default.
// - Remote system reset keeps interface settings and interrupt registers; control, result, outputs, presets reset.
// - Trigger, then end and conversion flags, then controller samples judgments.
// - After trigger and end, value read as digit and range bits via half select.
// - Preset chosen by four select inputs is loaded; a trigger may follow.
// - Two general inputs readable, three general outputs, on shared lines.
// - Port drives end and judgment outputs, accepts trigger and key-lock.
// - Preset load starts only after selects stay unchanged for 10 ms.
// - Half select low shows high digits; high shows low digits plus range.
// - End flag means judgment, fault and digit outputs are already final.
// - Trigger acts on chosen edge, only with external triggering selected.
module ecp_port
   import ecp_pkg::*;
#(
   parameter int NPRESET      = 16,
   parameter int QUIET_CYCLES = (`ECP_QUIET_MS * `ECP_CLK_HZ) / 1000
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output ecp_resp_t        s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output ecp_resp_t        s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // control inputs from the controller
   input  wire logic        measure_start,
   input  wire logic        zero_adjust_req,
   input  wire logic        print_req,
   input  wire logic        key_lock,
   input  wire logic        digit_half_select,
   input  wire logic [3:0]  preset_sel,
   // outputs to the controller
   output logic             measurement_end,
   output logic             conversion_done,
   output logic             judge_above,
   output logic             judge_pass,
   output logic             judge_under,
   output logic             measure_fault,
   output logic [11:0]      decimal_digit_bits,
   output logic [3:0]       range_code_bits,
   output logic             gp_output_0,
   output logic             gp_output_1,
   output logic             gp_output_2,
   // interrupt
   output logic             irq
);
   if (NPRESET < 1 || NPRESET > 16) $error("ecp_port: NPRESET must be 1..16");
   if (QUIET_CYCLES < 2 || QUIET_CYCLES > 262143) $error("ecp_port: QUIET_CYCLES out of range");

   logic [8:0] pins_s;
   logic [8:0] pins_q;
   wire measure_start_s  = pins_s[0];
   wire zadj_s  = pins_s[1];
   wire print_s = pins_s[2];
   wire lock_s  = pins_s[3];
   wire half_s  = pins_s[4];
   wire [3:0] sel_s = pins_s[8:5];

   ecp_sync #(.W(9)) u_sync (
      .clk  (clk),
      .rst  (rst),
      .din  ({preset_sel, digit_half_select, key_lock, print_req, zero_adjust_req, measure_start}),
      .dout (pins_s)
   );

   logic        wr_en;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic [7:0]  rd_addr;
   logic [31:0] rd_data;
   logic        wr_hit;
   logic        rd_hit;

   ecp_axil u_axil (
      .clk       (clk),
      .rst       (rst),
      .s_awaddr  (s_awaddr),
      .s_awvalid (s_awvalid),
      .s_awready (s_awready),
      .s_wdata   (s_wdata),
      .s_wstrb   (s_wstrb),
      .s_wvalid  (s_wvalid),
      .s_wready  (s_wready),
      .s_bresp   (s_bresp),
      .s_bvalid  (s_bvalid),
      .s_bready  (s_bready),
      .s_araddr  (s_araddr),
      .s_arvalid (s_arvalid),
      .s_arready (s_arready),
      .s_rdata   (s_rdata),
      .s_rresp   (s_rresp),
      .s_rvalid  (s_rvalid),
      .s_rready  (s_rready),
      .wr_en     (wr_en),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data),
      .wr_strb   (wr_strb),
      .wr_hit    (wr_hit),
      .rd_addr   (rd_addr),
      .rd_data   (rd_data),
      .rd_hit    (rd_hit)
   );

   ecp_state_t  state;
   logic [31:0] ctrl;
   logic [31:0] result;
   logic [31:0] if_cfg;
   logic [4:0]  irq_stat;
   logic [4:0]  irq_mask;
   logic [31:0] preset_mem [NPRESET];
   logic [3:0]  clr_idx;
   logic [17:0] quiet_cnt;
   logic        quiet_armed;

   // write decode
   wire [31:0] wmask    = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   wire        w_ctrl   = wr_en && wr_addr == `ECP_OFF_CTRL;
   wire        w_istat  = wr_en && wr_addr == `ECP_OFF_IRQ_STAT;
   wire        w_imask  = wr_en && wr_addr == `ECP_OFF_IRQ_MASK;
   wire        w_result = wr_en && wr_addr == `ECP_OFF_RESULT;
   wire        w_conv   = wr_en && wr_addr == `ECP_OFF_CONV;
   wire        w_reset  = wr_en && wr_addr == `ECP_OFF_RESET;
   wire        w_ifcfg  = wr_en && wr_addr == `ECP_OFF_IF_CFG;
   wire        w_save   = wr_en && wr_addr == `ECP_OFF_SAVE;
   wire        cmd_meas = w_reset && wr_data[`ECP_RST_MEAS];
   wire        cmd_sys  = w_reset && wr_data[`ECP_RST_SYS];
   wire        cmd_any  = cmd_meas || cmd_sys;
   wire        keep_if  = w_reset && wr_data[`ECP_RST_REMOTE];
   assign wr_hit = w_ctrl || w_istat || w_imask || w_result || w_conv || w_reset || w_ifcfg
                   || w_save || (wr_en && wr_addr == `ECP_OFF_STATUS);

   // input events
   wire measure_start_edge = ctrl[`ECP_CTRL_FALL] ? (pins_q[0] && !measure_start_s) : (!pins_q[0] && measure_start_s);
   wire measure_start_go   = measure_start_edge && ctrl[`ECP_CTRL_EXT] && state == ECP_IDLE;
   wire zadj_go   = zadj_s && !pins_q[1] && state == ECP_IDLE;
   wire print_go  = print_s && !pins_q[2];
   wire sel_chg   = sel_s != pins_q[8:5];
   wire load_go   = quiet_armed && !sel_chg && quiet_cnt == 18'(QUIET_CYCLES - 1)
                    && state != ECP_CLEAR;
   wire sel_ok    = 32'(sel_s) < NPRESET;
   wire end_go    = w_result && state == ECP_BUSY;
   wire [4:0] events = {end_go, load_go, print_go, zadj_go, measure_start_go};

   // read decode
   wire [31:0] status_word = {19'h0, sel_s, half_s, pins_s[2], pins_s[0], lock_s, state == ECP_BUSY,
                              state == ECP_CLEAR, measurement_end, conversion_done};
   assign rd_hit = rd_addr inside {`ECP_OFF_CTRL, `ECP_OFF_STATUS, `ECP_OFF_IRQ_STAT,
                   `ECP_OFF_IRQ_MASK, `ECP_OFF_RESULT, `ECP_OFF_CONV, `ECP_OFF_RESET,
                   `ECP_OFF_IF_CFG, `ECP_OFF_SAVE};
   assign rd_data = rd_addr == `ECP_OFF_CTRL     ? ctrl :
                    rd_addr == `ECP_OFF_STATUS   ? status_word :
                    rd_addr == `ECP_OFF_IRQ_STAT ? {27'h0, irq_stat} :
                    rd_addr == `ECP_OFF_IRQ_MASK ? {27'h0, irq_mask} :
                    rd_addr == `ECP_OFF_RESULT   ? result :
                    rd_addr == `ECP_OFF_IF_CFG   ? if_cfg : 32'h0000_0000;

   always_ff @(posedge clk) begin
      if (rst) begin
         pins_q <= 9'h000;
      end else begin
         pins_q <= pins_s;
      end
   end

   // measurement sequencing and preset clearing
   always_ff @(posedge clk) begin
      if (rst) begin
         state   <= ECP_IDLE;
         clr_idx <= 4'h0;
      end else begin
         unique case (state)
            ECP_IDLE: begin
               if (cmd_sys) begin
                  state   <= ECP_CLEAR;
                  clr_idx <= 4'h0;
               end else if (measure_start_go || zadj_go) begin
                  state <= ECP_BUSY;
               end
            end
            ECP_BUSY: begin
               if (cmd_sys) begin
                  state   <= ECP_CLEAR;
                  clr_idx <= 4'h0;
               end else if (w_result || cmd_meas) begin
                  state <= ECP_IDLE;
               end
            end
            ECP_CLEAR: begin
               clr_idx <= clr_idx + 4'h1;
               if (32'(clr_idx) == NPRESET - 1) state <= ECP_IDLE;
            end
         endcase
      end
   end

   // preset store, cleared one entry per cycle on system reset
   always_ff @(posedge clk) begin
      if (state == ECP_CLEAR) begin
         preset_mem[clr_idx] <= `ECP_CTRL_DEF;
      end else if (w_save && 32'(wr_data[3:0]) < NPRESET) begin
         preset_mem[wr_data[3:0]] <= ctrl;
      end
   end

   // settings registers
   always_ff @(posedge clk) begin
      if (rst || cmd_any) begin
         ctrl <= `ECP_CTRL_DEF;
      end else if (load_go && sel_ok) begin
         ctrl <= preset_mem[sel_s];
      end else if (w_ctrl) begin
         ctrl <= (ctrl & ~wmask) | (wr_data & wmask);
      end
   end

   always_ff @(posedge clk) begin
      if (rst || (cmd_any && !keep_if)) begin
         if_cfg <= `ECP_IF_CFG_DEF;
      end else if (w_ifcfg) begin
         if_cfg <= (if_cfg & ~wmask) | (wr_data & wmask);
      end
   end

   always_ff @(posedge clk) begin
      if (rst || cmd_any) begin
         result <= 32'h0000_0000;
      end else if (end_go) begin
         result <= (result & ~wmask) | (wr_data & wmask);
      end
   end

   // quiet-interval timer for preset selection
   always_ff @(posedge clk) begin
      if (rst) begin
         quiet_cnt   <= 18'h00000;
         quiet_armed <= 1'b0;
      end else if (sel_chg) begin
         quiet_cnt   <= 18'h00000;
         quiet_armed <= 1'b1;
      end else if (load_go) begin
         quiet_armed <= 1'b0;
      end else if (quiet_armed) begin
         quiet_cnt <= quiet_cnt + 18'h00001;
      end
   end

   // sticky events: a set in the clearing cycle wins
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_stat <= 5'h00;
         irq_mask <= 5'h00;
         irq      <= 1'b0;
      end else begin
         irq_stat <= (irq_stat & ~(w_istat ? wr_data[4:0] : 5'h00)) | events;
         if (w_imask) irq_mask <= wr_data[4:0];
         irq <= |(((irq_stat & ~(w_istat ? wr_data[4:0] : 5'h00)) | events) & irq_mask);
      end
   end

   // controller-facing outputs, all registered
   wire bcd_mode = ctrl[`ECP_CTRL_BCD];
   // digits follow the incoming result so they are final when the end flag rises
   wire [31:0] next_result = end_go ? ((result & ~wmask) | (wr_data & wmask)) : result;
   wire [11:0] next_digits = !bcd_mode ? 12'h000 :
                             half_s ? {4'h0, next_result[7:0]} : next_result[19:8];
   wire [3:0]  next_range  = (bcd_mode && half_s) ? next_result[`ECP_RES_RANGE_LO +: 4] : 4'h0;
   wire [2:0]  next_gp     = bcd_mode ? next_result[19:17] : ctrl[`ECP_CTRL_GP_LO +: 3];

   always_ff @(posedge clk) begin
      if (rst || cmd_any) begin
         measurement_end <= 1'b0;
         conversion_done <= 1'b0;
      end else if (measure_start_go || zadj_go) begin
         measurement_end <= 1'b0;
         conversion_done <= 1'b0;
      end else begin
         if (end_go) measurement_end <= 1'b1;
         if (w_conv && state == ECP_BUSY) conversion_done <= 1'b1;
         if (end_go) conversion_done <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || cmd_any) begin
         judge_above   <= 1'b0;
         judge_pass    <= 1'b0;
         judge_under   <= 1'b0;
         measure_fault <= 1'b0;
      end else if (end_go) begin
         judge_above   <= wr_data[`ECP_RES_ABOVE] && !bcd_mode;
         judge_pass    <= wr_data[`ECP_RES_PASS] && !bcd_mode;
         judge_under   <= wr_data[`ECP_RES_UNDER] && !bcd_mode;
         measure_fault <= wr_data[`ECP_RES_FAULT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         decimal_digit_bits <= 12'h000;
         range_code_bits    <= 4'h0;
         {gp_output_2, gp_output_1, gp_output_0} <= 3'h0;
      end else begin
         decimal_digit_bits <= next_digits;
         range_code_bits    <= next_range;
         {gp_output_2, gp_output_1, gp_output_0} <= next_gp;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_MEASURE_START_STARTS: assert property (measure_start_edge && ctrl[`ECP_CTRL_EXT] && state == ECP_IDLE && !cmd_sys
      |=> state == ECP_BUSY && !measurement_end) else $error("enabled trigger edge did not start");
   AST_MEASURE_START_IGNORED: assert property (!ctrl[`ECP_CTRL_EXT] && !zadj_go && state == ECP_IDLE
      |=> state != ECP_BUSY) else $error("trigger acted with internal triggering");
   AST_END_FINAL: assert property ($rose(measurement_end) |-> measure_fault == result[`ECP_RES_FAULT]
      && conversion_done) else $error("end flag raised before outputs were final");
   AST_NO_END_BUSY: assert property (state == ECP_BUSY && !$rose(state == ECP_BUSY)
      |-> !measurement_end) else $error("end flag high during measurement");
   AST_HALF_SELECT: assert property (bcd_mode && $stable(half_s) && $stable(result) && !half_s
      |=> decimal_digit_bits == result[19:8]) else $error("high digits not shown");
   AST_LOAD_QUIET: assert property (load_go && sel_ok && !cmd_any
      |-> $stable(sel_s) ##1 ctrl == $past(preset_mem[sel_s])) else $error("preset load wrong");
   AST_SYS_CLEAR: assert property (cmd_sys && state != ECP_CLEAR
      |=> state == ECP_CLEAR ##[1:16] state == ECP_IDLE) else $error("system reset did not clear presets");
   AST_REMOTE_KEEP: assert property (cmd_any && keep_if && !w_ifcfg
      |=> if_cfg == $past(if_cfg) && ctrl == `ECP_CTRL_DEF) else $error("remote reset touched interface");
   AST_LOCK_SEEN: assert property (key_lock ##1 key_lock ##1 key_lock
      |-> lock_s) else $error("key lock not seen after two edges");
   AST_GP_OUT: assert property (!bcd_mode
      |=> {gp_output_2, gp_output_1, gp_output_0} == $past(ctrl[`ECP_CTRL_GP_LO +: 3]))
      else $error("general output wrong");
   AST_DIGIT_AFTER_END: assert property ($rose(measurement_end) && $past(bcd_mode)
      |-> decimal_digit_bits == ($past(half_s) ? {4'h0, result[7:0]} : result[19:8])
      && range_code_bits == ($past(half_s) ? result[`ECP_RES_RANGE_LO +: 4] : 4'h0))
      else $error("digits not final at end");
endmodule : ecp_port
`default_nettype wire

/* ecp_plc.sv */
/*
 * Controller model driving the parallel control lines of the port.
 * Assumes the bench calls its tasks from the clk domain, one at a time.
 */
`timescale 1ns/1ps
`default_nettype none
module ecp_plc #(
   parameter int HOLD = 30
) (
   // clock
   input  wire logic  clk,
   // control lines
   output logic       measure_start,
   output logic       zero_adjust_req,
   output logic       print_req,
   output logic       key_lock,
   output logic       digit_half_select,
   output logic [3:0] preset_sel
);
   initial begin
      {measure_start, zero_adjust_req, print_req, key_lock, digit_half_select, preset_sel} = 9'h000;
   end
   // caller only retriggers after measurement_end
   task lines(input logic [3:0] v);
      @(posedge clk);
      {measure_start, print_req, key_lock, digit_half_select} <= v;
   endtask : lines
   // held well past the scaled quiet time
   task zadj();
      @(posedge clk);
      zero_adjust_req <= 1'b1;
      repeat (HOLD) @(posedge clk);
      zero_adjust_req <= 1'b0;
   endtask : zadj
   // selects stay put until the next call
   task sel(input logic [3:0] v);
      @(posedge clk);
      preset_sel <= v;
   endtask : sel
endmodule : ecp_plc
`default_nettype wire

/* external_control_port_test.sv */
/*
 * Self-checking bench of the external control port with a controller model.
 * Assumes ecp_port with a shortened quiet time and ecp_plc on the pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ecp_cfg.svh"
module external_control_port_test;
   import ecp_pkg::*;
   localparam int Q = 20;
   logic clk, rst, aw_v, w_v, b_r, ar_v, r_r, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic measure_start, zero_adjust_req, print_req, key_lock, digit_half_select, ia, ib;
   logic measurement_end, conversion_done, ja, jp, ju, mf, gp0, gp1, gp2, irq;
   logic [7:0]  aw_a, ar_a;
   logic [31:0] w_d, s_rdata, res, m_ctrl, m_if;
   logic [3:0]  preset_sel, range_code_bits, ej;
   logic [11:0] decimal_digit_bits;
   ecp_resp_t   s_bresp, s_rresp;
   int          err_total, n_checks;
   ecp_port #(.QUIET_CYCLES(Q)) ecp_port_inst (.clk(clk), .rst(rst), .s_awaddr(aw_a), .s_awvalid(aw_v),
      .s_awready(s_awready), .s_wdata(w_d), .s_wstrb(4'hF), .s_wvalid(w_v), .s_wready(s_wready),
      .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(b_r), .s_araddr(ar_a), .s_arvalid(ar_v),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(r_r),
      .measure_start(measure_start), .zero_adjust_req(zero_adjust_req), .print_req(print_req),
      .key_lock(key_lock), .digit_half_select(digit_half_select), .preset_sel(preset_sel),
      .measurement_end(measurement_end), .conversion_done(conversion_done), .judge_above(ja),
      .judge_pass(jp), .judge_under(ju), .measure_fault(mf), .decimal_digit_bits(decimal_digit_bits),
      .range_code_bits(range_code_bits), .gp_output_0(gp0), .gp_output_1(gp1), .gp_output_2(gp2), .irq(irq));
   ecp_plc #(.HOLD(Q + 10)) ecp_plc_inst (.clk(clk), .measure_start(measure_start),
      .zero_adjust_req(zero_adjust_req), .print_req(print_req), .key_lock(key_lock),
      .digit_half_select(digit_half_select), .preset_sel(preset_sel));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task chk(input logic [31:0] seen, input logic [31:0] e);
      n_checks++;
      if (seen !== e) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, e);
      end
   endtask : chk
   // unmapped offsets lie above the save register
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {aw_a, w_d, aw_v, w_v, b_r} <= {a, d, 3'h7};
      @(negedge clk);
      while (!(s_awready && s_wready)) @(negedge clk);
      @(posedge clk);
      {aw_v, w_v} <= 2'h0;
      @(negedge clk);
      while (!s_bvalid) @(negedge clk);
      chk({30'h0, s_bresp}, (a > `ECP_OFF_SAVE) ? {30'h0, ECP_DECERR} : {30'h0, ECP_OKAY});
      @(posedge clk);
      b_r <= 1'b0;
   endtask : wr
   task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk);
      {ar_a, ar_v, r_r} <= {a, 2'h3};
      @(negedge clk);
      while (!s_arready) @(negedge clk);
      @(posedge clk);
      ar_v <= 1'b0;
      @(negedge clk);
      while (!s_rvalid) @(negedge clk);
      chk(s_rdata & m, e);
      if (a > `ECP_OFF_SAVE) chk({30'h0, s_rresp}, {30'h0, ECP_DECERR});
      @(posedge clk);
      r_r <= 1'b0;
   endtask : rchk
   task end_of_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test
   initial begin
      cyc(30000);
      err_total++;
      end_of_test();
   end
   initial begin
      {aw_v, w_v, b_r, ar_v, r_r, aw_a, ar_a, w_d} = 53'h0;
      {err_total, n_checks} = 64'h0;
      rst = 1'b1;
      void'($urandom(11724));
      cyc(16);
      rst <= 1'b0;
      rchk(`ECP_OFF_CTRL, 32'hFFFF_FFFF, `ECP_CTRL_DEF);
      rchk(`ECP_OFF_IF_CFG, 32'hFFFF_FFFF, `ECP_IF_CFG_DEF);
      rchk(8'h40, 32'hFFFF_FFFF, 32'h0);
      wr(8'h44, 32'h1);
      wr(`ECP_OFF_RESET, 32'h2);
      cyc(24);
      rchk(`ECP_OFF_STATUS, 32'h4, 32'h0);
      // internal trigger selected: start level must be ignored
      ecp_plc_inst.lines(4'hE);
      cyc(6);
      rchk(`ECP_OFF_STATUS, 32'h78, 32'h70);
      ecp_plc_inst.lines(4'h0);
      ecp_plc_inst.zadj();
      cyc(4);
      rchk(`ECP_OFF_IRQ_STAT, 32'h7, 32'h6);
      wr(`ECP_OFF_IRQ_MASK, 32'h1F);
      cyc(2);
      ia = irq;
      wr(`ECP_OFF_IRQ_MASK, 32'h0);
      cyc(2);
      ib = irq;
      chk({30'h0, ia, ib}, 32'h2);
      wr(`ECP_OFF_IRQ_STAT, 32'h1F);
      cyc(2);
      rchk(`ECP_OFF_IRQ_STAT, 32'h1F, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(`ECP_OFF_RESET, 32'h1);
      for (int k = 0; k < 4; k++) begin
         m_ctrl = {25'h0, 3'h5, 1'b0, k[1], k[0], 1'b1};
         res = $urandom & 32'h0FFF_FFFF;
         for (int i = 0; i < 5; i++) res[4*i+:4] = 4'($urandom % 10);
         wr(`ECP_OFF_CTRL, m_ctrl);
         ecp_plc_inst.lines({k[0], 3'h0});
         cyc(6);
         rchk(`ECP_OFF_STATUS, 32'h8, 32'h0);
         ecp_plc_inst.lines({~k[0], 3'h0});
         cyc(6);
         rchk(`ECP_OFF_STATUS, 32'h8, 32'h8);
         chk({31'h0, measurement_end}, 32'h0);
         wr(`ECP_OFF_CONV, 32'h1);
         cyc(2);
         chk({30'h0, conversion_done, measurement_end}, 32'h2);
         wr(`ECP_OFF_RESULT, res);
         cyc(2);
         ej = k[1] ? {3'h0, res[27]} : {res[24], res[25], res[26], res[27]};
         chk({30'h0, measurement_end, conversion_done}, 32'h3);
         chk({28'h0, ja, jp, ju, mf}, {28'h0, ej});
         chk({29'h0, gp2, gp1, gp0}, k[1] ? {29'h0, res[19:17]} : 32'h5);
         if (k[1]) begin
            chk({20'h0, decimal_digit_bits}, {20'h0, res[19:8]});
            ecp_plc_inst.lines({~k[0], 3'h1});
            cyc(6);
            chk({16'h0, range_code_bits, decimal_digit_bits}, {16'h0, res[23:20], 4'h0, res[7:0]});
            ecp_plc_inst.lines({~k[0], 3'h0});
         end
      end
      m_ctrl = ($urandom & 32'h77) | 32'h10;
      wr(`ECP_OFF_CTRL, m_ctrl);
      wr(`ECP_OFF_SAVE, 32'h5);
      wr(`ECP_OFF_SAVE, 32'h0);
      wr(`ECP_OFF_CTRL, 32'h0);
      ecp_plc_inst.sel(4'h5);
      cyc(Q - 8);
      rchk(`ECP_OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
      cyc(Q);
      rchk(`ECP_OFF_CTRL, 32'hFFFF_FFFF, m_ctrl);
      rchk(`ECP_OFF_STATUS, 32'hF00, 32'h500);
      rchk(`ECP_OFF_IRQ_STAT, 32'h8, 32'h8);
      m_if = $urandom;
      wr(`ECP_OFF_IF_CFG, m_if);
      wr(`ECP_OFF_RESET, 32'h6);
      cyc(24);
      rchk(`ECP_OFF_IF_CFG, 32'hFFFF_FFFF, m_if);
      rchk(`ECP_OFF_CTRL, 32'hFFFF_FFFF, `ECP_CTRL_DEF);
      wr(`ECP_OFF_CTRL, 32'h70);
      ecp_plc_inst.sel(4'h0);
      cyc(2 * Q);
      rchk(`ECP_OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
      wr(`ECP_OFF_RESET, 32'h2);
      cyc(24);
      rchk(`ECP_OFF_IF_CFG, 32'hFFFF_FFFF, `ECP_IF_CFG_DEF);
      end_of_test();
   end
endmodule : external_control_port_test
`default_nettype wire
